// ---- src/seg_sel_unit.sv ----
`timescale 1ns/1ps
`include "seg_sel_map.svh"
module seg_sel_unit (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    // Mode and global table register
    input wire logic mode64_in,
    input wire logic [63:0] gtab_base_in,
    input wire logic [15:0] gtab_limit_in,
    // Segment load
    input wire logic load_req_in,
    input wire seg_sel_pkg::seg_idx_type load_seg_in,
    input wire logic [15:0] load_sel_in,
    output logic load_done_out,
    output logic fault_out,
    // Descriptor fetch
    output logic desc_req_out,
    output logic [63:0] desc_addr_out,
    input wire logic desc_ack_in,
    input wire logic [63:0] desc_data_in,
    // Model register access
    input wire logic mreg_wr_in,
    input wire logic mreg_rd_in,
    input wire logic [31:0] mreg_addr_in,
    input wire logic [63:0] mreg_wdata_in,
    output logic [63:0] mreg_rdata_out,
    output logic mreg_rvalid_out,
    // Address generation
    input wire logic ea_req_in,
    input wire logic ea_ovr_in,
    input wire seg_sel_pkg::seg_idx_type ea_ovr_seg_in,
    input wire seg_sel_pkg::acc_kind_type ea_kind_in,
    input wire logic [63:0] ea_offset_in,
    output logic ea_valid_out,
    output logic [63:0] ea_out,
    output logic ea_fault_out,
    // Privilege, code attributes, selector readback
    output logic [1:0] cur_priv_out,
    output logic cs_long_out,
    output logic cs_dsize_out,
    input wire seg_sel_pkg::seg_idx_type selr_seg_in,
    output logic [15:0] selr_data_out
);
    import seg_sel_pkg::*;

    function automatic logic is_null(input logic [15:0] s);
        is_null = (s[`SEL_IDX_HI:`SEL_TSEL_BIT] == '0);
    endfunction

    function automatic logic canon(input logic [63:0] a);
        canon = (&a[63:`VA_MSB]) | ~(|a[63:`VA_MSB]);
    endfunction

    fsm_state_type state_r, state_nxt;
    logic [15:0] sel_r [`NUM_SEGS];
    logic [15:0] sel_nxt [`NUM_SEGS];
    logic [63:0] base_r [`NUM_SEGS];
    logic [63:0] base_nxt [`NUM_SEGS];
    logic [31:0] lim_r [`NUM_SEGS];
    logic [31:0] lim_nxt [`NUM_SEGS];
    logic [1:0] dpl_r [`NUM_SEGS];
    logic [1:0] dpl_nxt [`NUM_SEGS];
    logic [`NUM_SEGS-1:0] l_r, l_nxt, d_r, d_nxt;
    logic [1:0] cpl_r, cpl_nxt;
    seg_idx_type ld_seg_r, ld_seg_nxt;
    logic [15:0] ld_sel_r, ld_sel_nxt;
    logic done_r, done_nxt, fault_r, fault_nxt;
    logic dreq_r, dreq_nxt;
    logic [63:0] daddr_r, daddr_nxt;
    logic mrv_r, mrv_nxt;
    logic [63:0] mrd_r, mrd_nxt;
    logic [15:0] selr_r, selr_nxt;
    logic eav_r, eav_nxt, eaf_r, eaf_nxt;
    logic [63:0] ea_r, ea_nxt;
    logic ack_ok;

    always_comb begin : load_comb
        logic [63:0] tbl_base;
        logic [31:0] lim_w;
        logic [19:0] lim20;
        logic [1:0] eff;
        logic bad;
        tbl_base = '0;
        lim_w = '0;
        lim20 = '0;
        eff = '0;
        bad = 1'b0;
        ack_ok = 1'b0;
        state_nxt = state_r;
        for (int i = 0; i < `NUM_SEGS; i++) begin
            sel_nxt[i] = sel_r[i];
            base_nxt[i] = base_r[i];
            lim_nxt[i] = lim_r[i];
            dpl_nxt[i] = dpl_r[i];
        end
        l_nxt = l_r;
        d_nxt = d_r;
        cpl_nxt = cpl_r;
        ld_seg_nxt = ld_seg_r;
        ld_sel_nxt = ld_sel_r;
        done_nxt = 1'b0;
        fault_nxt = 1'b0;
        dreq_nxt = dreq_r;
        daddr_nxt = daddr_r;
        mrv_nxt = 1'b0;
        mrd_nxt = mrd_r;
        selr_nxt = (selr_seg_in < `SEG_LTAB) ? sel_r[selr_seg_in] : '0;
        unique case (state_r)
            ST_IDLE: begin
                if (load_req_in) begin
                    if (load_sel_in[`SEL_TSEL_BIT]) begin
                        tbl_base = base_r[`SEG_LTAB];
                        bad = is_null(sel_r[`SEG_LTAB]) ||
                            ({16'h0, load_sel_in[`SEL_IDX_HI:`SEL_IDX_LO],
                            `DESC_LAST_BYTE} > lim_r[`SEG_LTAB]);
                    end else begin
                        tbl_base = gtab_base_in;
                        bad = ({load_sel_in[`SEL_IDX_HI:`SEL_IDX_LO],
                            `DESC_LAST_BYTE} > gtab_limit_in);
                    end
                    if (is_null(load_sel_in)) begin
                        if (load_seg_in == `SEG_CODE ||
                            (load_seg_in == `SEG_STACK &&
                            (!mode64_in || cpl_r == `PRIV_USER))) begin
                            fault_nxt = 1'b1;
                        end else if (load_seg_in < `NUM_SEGS) begin
                            sel_nxt[load_seg_in] = load_sel_in;
                            done_nxt = 1'b1;
                        end else begin
                            fault_nxt = 1'b1;
                        end
                    end else if (bad || load_seg_in >= `NUM_SEGS) begin
                        fault_nxt = 1'b1;
                    end else begin
                        ld_seg_nxt = load_seg_in;
                        ld_sel_nxt = load_sel_in;
                        dreq_nxt = 1'b1;
                        daddr_nxt = tbl_base + {48'h0,
                            load_sel_in[`SEL_IDX_HI:`SEL_IDX_LO],
                            `DESC_OFS_PAD};
                        state_nxt = ST_FETCH;
                    end
                end else if (mreg_wr_in && (mreg_addr_in == `MR_XFIRST_ADDR ||
                    mreg_addr_in == `MR_XSECOND_ADDR)) begin
                    if (cpl_r != `PRIV_KERNEL || !canon(mreg_wdata_in)) begin
                        fault_nxt = 1'b1;
                    end else if (mreg_addr_in == `MR_XFIRST_ADDR) begin
                        base_nxt[`SEG_XFIRST] = mreg_wdata_in;
                    end else begin
                        base_nxt[`SEG_XSECOND] = mreg_wdata_in;
                    end
                end
                if (mreg_rd_in) begin
                    mrv_nxt = 1'b1;
                    // Only the two extra bases are reachable
                    if (cpl_r != `PRIV_KERNEL) begin
                        mrd_nxt = '0;
                        fault_nxt = 1'b1;
                    end else if (mreg_addr_in == `MR_XFIRST_ADDR) begin
                        mrd_nxt = base_r[`SEG_XFIRST];
                    end else if (mreg_addr_in == `MR_XSECOND_ADDR) begin
                        mrd_nxt = base_r[`SEG_XSECOND];
                    end else begin
                        mrd_nxt = '0;
                    end
                end
            end
            ST_FETCH: begin
                if (desc_ack_in) begin
                    eff = (cpl_r > ld_sel_r[`SEL_RP_HI:`SEL_RP_LO]) ?
                        cpl_r : ld_sel_r[`SEL_RP_HI:`SEL_RP_LO];
                    bad = !desc_data_in[`DESC_PRES_BIT];
                    if (ld_seg_r == `SEG_STACK) begin
                        bad = bad ||
                            ld_sel_r[`SEL_RP_HI:`SEL_RP_LO] != cpl_r ||
                            desc_data_in[`DESC_DPL_HI:`DESC_DPL_LO] != cpl_r;
                    end else if (ld_seg_r != `SEG_CODE &&
                        ld_seg_r != `SEG_LTAB) begin
                        bad = bad ||
                            eff > desc_data_in[`DESC_DPL_HI:`DESC_DPL_LO];
                    end
                    lim20 = {desc_data_in[`DESC_LIM_HI_HI:`DESC_LIM_HI_LO],
                        desc_data_in[`DESC_LIM_LO_HI:`DESC_LIM_LO_LO]};
                    lim_w = desc_data_in[`DESC_G_BIT] ?
                        {lim20, `GRAN_FILL} : {12'h0, lim20};
                    dreq_nxt = 1'b0;
                    state_nxt = ST_IDLE;
                    ack_ok = !bad;
                    fault_nxt = bad;
                    done_nxt = !bad;
                    if (!bad) begin
                        sel_nxt[ld_seg_r] = ld_sel_r;
                        base_nxt[ld_seg_r] = {32'h0,
                            desc_data_in[`DESC_BASE_HI_HI:`DESC_BASE_HI_LO],
                            desc_data_in[`DESC_BASE_LO_HI:`DESC_BASE_LO_LO]
                            };
                        lim_nxt[ld_seg_r] = lim_w;
                        dpl_nxt[ld_seg_r] =
                            desc_data_in[`DESC_DPL_HI:`DESC_DPL_LO];
                        l_nxt[ld_seg_r] = desc_data_in[`DESC_L_BIT];
                        d_nxt[ld_seg_r] = desc_data_in[`DESC_D_BIT];
                        if (ld_seg_r == `SEG_CODE) begin
                            cpl_nxt =
                                desc_data_in[`DESC_DPL_HI:`DESC_DPL_LO];
                        end
                    end
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_r <= ST_IDLE;
            for (int i = 0; i < `NUM_SEGS; i++) begin
                sel_r[i] <= '0;
                base_r[i] <= '0;
                lim_r[i] <= '0;
                dpl_r[i] <= '0;
            end
            l_r <= '0;
            d_r <= '0;
            cpl_r <= `PRIV_KERNEL;
            ld_seg_r <= `SEG_CODE;
            ld_sel_r <= '0;
            done_r <= 1'b0;
            fault_r <= 1'b0;
            dreq_r <= 1'b0;
            daddr_r <= '0;
            mrv_r <= 1'b0;
            mrd_r <= '0;
            selr_r <= '0;
        end else begin
            state_r <= state_nxt;
            for (int i = 0; i < `NUM_SEGS; i++) begin
                sel_r[i] <= sel_nxt[i];
                base_r[i] <= base_nxt[i];
                lim_r[i] <= lim_nxt[i];
                dpl_r[i] <= dpl_nxt[i];
            end
            l_r <= l_nxt;
            d_r <= d_nxt;
            cpl_r <= cpl_nxt;
            ld_seg_r <= ld_seg_nxt;
            ld_sel_r <= ld_sel_nxt;
            done_r <= done_nxt;
            fault_r <= fault_nxt;
            dreq_r <= dreq_nxt;
            daddr_r <= daddr_nxt;
            mrv_r <= mrv_nxt;
            mrd_r <= mrd_nxt;
            selr_r <= selr_nxt;
        end
    end

    always_comb begin : ea_comb
        seg_idx_type es;
        logic [31:0] sum32;
        es = `SEG_DATA;
        sum32 = '0;
        if (ea_ovr_in) begin
            es = ea_ovr_seg_in;
        end else begin
            unique case (ea_kind_in)
                ACC_DATA: es = `SEG_DATA;
                ACC_SDEST: es = `SEG_SDEST;
                ACC_STACK: es = `SEG_STACK;
                ACC_CODE: es = `SEG_CODE;
            endcase
        end
        eav_nxt = ea_req_in;
        ea_nxt = ea_r;
        eaf_nxt = 1'b0;
        if (ea_req_in) begin
            if (es >= `SEG_LTAB) begin
                ea_nxt = '0;
                eaf_nxt = 1'b1;
            end else if (mode64_in) begin
                if (es == `SEG_XFIRST || es == `SEG_XSECOND) begin
                    ea_nxt = base_r[es] + ea_offset_in;
                end else begin
                    ea_nxt = ea_offset_in;
                end
                eaf_nxt = !canon(ea_nxt);
            end else begin
                sum32 = base_r[es][31:0] + ea_offset_in[31:0];
                ea_nxt = {32'h0, sum32};
                eaf_nxt = is_null(sel_r[es]) ||
                    ea_offset_in[31:0] > lim_r[es];
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            eav_r <= 1'b0;
            ea_r <= '0;
            eaf_r <= 1'b0;
        end else begin
            eav_r <= eav_nxt;
            ea_r <= ea_nxt;
            eaf_r <= eaf_nxt;
        end
    end

    assign load_done_out = done_r;
    assign fault_out = fault_r;
    assign desc_req_out = dreq_r;
    assign desc_addr_out = daddr_r;
    assign mreg_rdata_out = mrd_r;
    assign mreg_rvalid_out = mrv_r;
    assign ea_valid_out = eav_r;
    assign ea_out = ea_r;
    assign ea_fault_out = eaf_r;
    assign cur_priv_out = cpl_r;
    assign cs_long_out = l_r[`SEG_CODE];
    assign cs_dsize_out = d_r[`SEG_CODE];
    assign selr_data_out = selr_r;

    entry_addr_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_b_in)
        $rose(dreq_r) && !$past(load_sel_in[`SEL_TSEL_BIT]) |->
        daddr_r == $past(gtab_base_in) + {48'h0,
        $past(load_sel_in[`SEL_IDX_HI:`SEL_IDX_LO]), `DESC_OFS_PAD})
        else $error("descriptor address wrong");
    cpl_set_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_b_in)
        state_r == ST_FETCH && ack_ok && ld_seg_r == `SEG_CODE |=>
        cpl_r == $past(desc_data_in[`DESC_DPL_HI:`DESC_DPL_LO]) && done_r)
        else $error("privilege not taken from code descriptor");
    null_code_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_b_in)
        state_r == ST_IDLE && load_req_in && load_seg_in == `SEG_CODE &&
        is_null(load_sel_in) |=> fault_r && !dreq_r && !done_r)
        else $error("null code load not faulted");
    null_data_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_b_in)
        state_r == ST_IDLE && load_req_in && load_seg_in == `SEG_DATA &&
        is_null(load_sel_in) |=> done_r && !fault_r &&
        sel_r[`SEG_DATA] == $past(load_sel_in))
        else $error("null data load refused");
    null_ref_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_b_in)
        ea_req_in && !mode64_in && !ea_ovr_in && ea_kind_in == ACC_DATA &&
        is_null(sel_r[`SEG_DATA]) |=> eav_r && eaf_r)
        else $error("null reference not faulted");
    flat64_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_b_in)
        ea_req_in && mode64_in && !ea_ovr_in |=>
        ea_r == $past(ea_offset_in) && eaf_r == !canon($past(ea_offset_in)))
        else $error("64-bit base not zero");
    mreg_noncanon_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_b_in)
        state_r == ST_IDLE && !load_req_in && mreg_wr_in &&
        mreg_addr_in == `MR_XFIRST_ADDR && !canon(mreg_wdata_in) |=>
        fault_r && $stable(base_r[`SEG_XFIRST]))
        else $error("bad base write accepted");
    gtab_limit_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_b_in)
        state_r == ST_IDLE && load_req_in && !is_null(load_sel_in) &&
        !load_sel_in[`SEL_TSEL_BIT] && {load_sel_in[`SEL_IDX_HI:
        `SEL_IDX_LO], `DESC_LAST_BYTE} > gtab_limit_in |=> fault_r && !dreq_r)
        else $error("limit overrun not faulted");
    base_clear_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_b_in)
        state_r == ST_FETCH && ack_ok && ld_seg_r == `SEG_XSECOND |=>
        base_r[`SEG_XSECOND][63:32] == 32'h0)
        else $error("upper base not cleared");
endmodule // seg_sel_unit

// ---- shared/seg_sel_map.svh ----
`ifndef SEG_SEL_MAP_SVH
`define SEG_SEL_MAP_SVH
`define NUM_SEGS 7
`define SEG_CODE 3'h0
`define SEG_DATA 3'h1
`define SEG_SDEST 3'h2
`define SEG_XFIRST 3'h3
`define SEG_XSECOND 3'h4
`define SEG_STACK 3'h5
`define SEG_LTAB 3'h6
`define SEL_IDX_HI 15
`define SEL_IDX_LO 3
`define SEL_TSEL_BIT 2
`define SEL_RP_HI 1
`define SEL_RP_LO 0
`define DESC_OFS_PAD 3'h0
`define DESC_LAST_BYTE 3'h7
`define DESC_DPL_HI 46
`define DESC_DPL_LO 45
`define DESC_PRES_BIT 47
`define DESC_L_BIT 53
`define DESC_D_BIT 54
`define DESC_G_BIT 55
`define DESC_LIM_HI_HI 51
`define DESC_LIM_HI_LO 48
`define DESC_LIM_LO_HI 15
`define DESC_LIM_LO_LO 0
`define DESC_BASE_HI_HI 63
`define DESC_BASE_HI_LO 56
`define DESC_BASE_LO_HI 39
`define DESC_BASE_LO_LO 16
`define GRAN_FILL 12'hFFF
`define MR_XFIRST_ADDR 32'hC0000100
`define MR_XSECOND_ADDR 32'hC0000101
`define VA_MSB 47
`define PRIV_KERNEL 2'h0
`define PRIV_USER 2'h3
`endif

// ---- shared/seg_sel_pkg.sv ----
package seg_sel_pkg;
    typedef logic [2:0] seg_idx_type;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_FETCH = 2'b10
    } fsm_state_type;
    typedef enum logic [1:0] {
        ACC_DATA = 2'h0,
        ACC_SDEST = 2'h1,
        ACC_STACK = 2'h2,
        ACC_CODE = 2'h3
    } acc_kind_type;
endpackage

// ---- sim/desc_fetch_model.sv ----
`timescale 1ns/1ps
module desc_fetch_model (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    // Descriptor fetch
    input wire logic desc_req_in,
    input wire logic [63:0] desc_addr_in,
    output logic desc_ack_out,
    output logic [63:0] desc_data_out,
    // Bench control
    input wire logic [63:0] entry_in,
    input wire logic [3:0] delay_in,
    output logic [63:0] last_addr_out
);
    logic [3:0] wait_r;

    // Data line changes every cycle outside the answer cycle
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            desc_ack_out <= 1'b0;
            desc_data_out <= 64'hA5A5_5A5A_A5A5_5A5A;
            wait_r <= 4'h0;
            last_addr_out <= 64'h0;
        end else if (desc_ack_out) begin
            desc_ack_out <= 1'b0;
            desc_data_out <= ~desc_data_out;
            wait_r <= 4'h0;
        end else if (desc_req_in) begin
            last_addr_out <= desc_addr_in;
            if (wait_r == delay_in) begin
                desc_ack_out <= 1'b1;
                desc_data_out <= entry_in;
            end else begin
                wait_r <= wait_r + 4'h1;
                desc_data_out <= ~desc_data_out;
            end
        end else begin
            desc_data_out <= ~desc_data_out;
        end
    end
endmodule // desc_fetch_model

// ---- sim/segment_selector_register_unit_tb.sv ----
`timescale 1ns/1ps
`include "seg_sel_map.svh"
module segment_selector_register_unit_tb;
    import seg_sel_pkg::*;
    logic clk, rst_b, mode64, load_req, load_done, fault;
    logic desc_req, desc_ack, mwr, mrd, mrvalid, ea_req, ea_ovr;
    logic ea_valid, ea_flt, cs_long, cs_dsize;
    logic [1:0] cur_priv;
    logic [3:0] dly;
    logic [15:0] glim, load_sel, selr_data;
    logic [31:0] maddr;
    logic [63:0] gbase, desc_addr, desc_data, mwdata, mrdata, ea_off, ea_val;
    logic [63:0] entry, last_addr;
    seg_idx_type load_seg, ea_oseg, selr_seg;
    acc_kind_type ea_kind;
    int err_total, checks;
    localparam logic [63:0] GB = 64'h0000_0000_0010_0000;

    seg_sel_unit i_dut (.sys_clk_in(clk), .rst_b_in(rst_b),
        .mode64_in(mode64), .gtab_base_in(gbase), .gtab_limit_in(glim),
        .load_req_in(load_req), .load_seg_in(load_seg),
        .load_sel_in(load_sel), .load_done_out(load_done),
        .fault_out(fault), .desc_req_out(desc_req),
        .desc_addr_out(desc_addr), .desc_ack_in(desc_ack),
        .desc_data_in(desc_data), .mreg_wr_in(mwr), .mreg_rd_in(mrd),
        .mreg_addr_in(maddr), .mreg_wdata_in(mwdata),
        .mreg_rdata_out(mrdata), .mreg_rvalid_out(mrvalid),
        .ea_req_in(ea_req), .ea_ovr_in(ea_ovr), .ea_ovr_seg_in(ea_oseg),
        .ea_kind_in(ea_kind), .ea_offset_in(ea_off),
        .ea_valid_out(ea_valid), .ea_out(ea_val), .ea_fault_out(ea_flt),
        .cur_priv_out(cur_priv), .cs_long_out(cs_long),
        .cs_dsize_out(cs_dsize), .selr_seg_in(selr_seg),
        .selr_data_out(selr_data));

    desc_fetch_model i_mem (.sys_clk_in(clk), .rst_b_in(rst_b),
        .desc_req_in(desc_req), .desc_addr_in(desc_addr),
        .desc_ack_out(desc_ack), .desc_data_out(desc_data),
        .entry_in(entry), .delay_in(dly), .last_addr_out(last_addr));

    always #4 clk = ~clk;

    task automatic chk(input logic [63:0] got, input logic [63:0] exp,
                       input string what);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error %0t: %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask

    function automatic logic [63:0] mk(input logic [31:0] b,
        input logic [19:0] lim, input logic [1:0] descriptor_priv_level, input logic g,
        input logic l);
        return {b[31:24], g, 1'b0, l, 1'b0, lim[19:16], 1'b1, descriptor_priv_level, 5'h12,
                b[23:0], lim[15:0]};
    endfunction

    task automatic do_load(input seg_idx_type s, input logic [15:0] sel,
                           input logic exp_f);
        int n;
        n = 0;
        @(posedge clk);
        load_req <= 1'b1;
        load_seg <= s;
        load_sel <= sel;
        @(posedge clk);
        load_req <= 1'b0;
        #1;
        while (load_done !== 1'b1 && fault !== 1'b1 && n < 40) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(load_done | fault, 1'b1, "load end");
        chk(fault, exp_f, "load fault");
    endtask

    task automatic do_mwr(input logic [31:0] a, input logic [63:0] d,
                          input logic exp_f);
        @(posedge clk);
        mwr <= 1'b1;
        maddr <= a;
        mwdata <= d;
        @(posedge clk);
        mwr <= 1'b0;
        #1;
        chk(fault, exp_f, "mreg write fault");
    endtask

    task automatic do_mrd(input logic [31:0] a, input logic [63:0] exp);
        @(posedge clk);
        mrd <= 1'b1;
        maddr <= a;
        @(posedge clk);
        mrd <= 1'b0;
        #1;
        chk(mrvalid, 1'b1, "mreg rvalid");
        chk(mrdata, exp, "mreg data");
    endtask

    task automatic do_ea(input acc_kind_type k, input logic o,
        input seg_idx_type s, input logic [63:0] off,
        input logic [63:0] exp, input logic exp_f);
        @(posedge clk);
        ea_req <= 1'b1;
        ea_kind <= k;
        ea_ovr <= o;
        ea_oseg <= s;
        ea_off <= off;
        @(posedge clk);
        ea_req <= 1'b0;
        #1;
        chk(ea_valid, 1'b1, "ea valid");
        chk(ea_flt, exp_f, "ea fault");
        if (!exp_f) begin
            chk(ea_val, exp, "ea value");
        end
    endtask

    task automatic rd_sel(input seg_idx_type s, input logic [15:0] exp);
        @(posedge clk);
        selr_seg <= s;
        @(posedge clk);
        #1;
        chk(selr_data, exp, "selector");
    endtask

    task automatic report_and_stop;
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        report_and_stop();
    end

    initial begin
        {clk, rst_b, mode64, load_req, mwr, mrd, ea_req, ea_ovr} = '0;
        {load_sel, maddr, mwdata, ea_off, entry, dly} = '0;
        load_seg = `SEG_CODE;
        ea_oseg = `SEG_CODE;
        selr_seg = `SEG_CODE;
        ea_kind = ACC_DATA;
        gbase = GB;
        glim = 16'h00FF;
        err_total = 0;
        checks = 0;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            rd_sel(seg_idx_type'(i), 16'h0000);
        end
        do_mrd(32'hC0000102, 64'h0);
        do_load(`SEG_DATA, 16'h000C, 1'b1);
        do_load(`SEG_DATA, 16'h0100, 1'b1);
        entry = mk(32'h12345000, 20'hFFFFF, 2'h0, 1'b1, 1'b0);
        do_load(`SEG_DATA, 16'h0013, 1'b1);
        rd_sel(`SEG_DATA, 16'h0000);
        entry = mk(32'h12345000, 20'hFFFFF, 2'h3, 1'b1, 1'b0);
        dly = 4'h5;
        do_load(`SEG_DATA, 16'h0010, 1'b0);
        chk(last_addr, GB + 64'h10, "entry addr");
        rd_sel(`SEG_DATA, 16'h0010);
        do_ea(ACC_DATA, 0, `SEG_CODE, 64'h100, 64'h12345100, 0);
        do_ea(ACC_SDEST, 0, `SEG_CODE, 64'h100, 64'h0, 1'b1);
        dly = 4'h0;
        entry = mk(32'h00200000, 20'h000FF, 2'h0, 1'b0, 1'b0);
        do_load(`SEG_LTAB, 16'h0020, 1'b0);
        entry = mk(32'h00400000, 20'hFFFFF, 2'h3, 1'b1, 1'b0);
        do_load(`SEG_SDEST, 16'h000C, 1'b0);
        chk(last_addr, 64'h0020_0008, "local entry addr");
        do_ea(ACC_SDEST, 0, `SEG_CODE, 64'h4, 64'h400004, 0);
        do_mwr(`MR_XFIRST_ADDR, 64'hFFFF_8000_0000_0000, 0);
        do_mrd(`MR_XFIRST_ADDR, 64'hFFFF_8000_0000_0000);
        do_mwr(`MR_XFIRST_ADDR, 64'h0000_8000_0000_0000, 1);
        do_mrd(`MR_XFIRST_ADDR, 64'hFFFF_8000_0000_0000);
        entry = mk(32'h00003000, 20'hFFFFF, 2'h3, 1'b1, 1'b0);
        do_load(`SEG_XFIRST, 16'h0018, 1'b0);
        do_mrd(`MR_XFIRST_ADDR, 64'h3000);
        do_mwr(`MR_XSECOND_ADDR, 64'h0000_7FFF_FFFF_F000, 0);
        do_mwr(`MR_XFIRST_ADDR, 64'hFFFF_FFFF_FFFF_F000, 0);
        @(posedge clk);
        mode64 <= 1'b1;
        rd_sel(`SEG_DATA, 16'h0010);
        do_ea(ACC_DATA, 1, `SEG_XFIRST, 64'h2000, 64'h1000, 0);
        do_ea(ACC_DATA, 1, `SEG_XSECOND, 64'h1000, 64'h0, 1);
        do_ea(ACC_DATA, 0, `SEG_CODE, 64'hFFFF_8000_0000_0010,
              64'hFFFF_8000_0000_0010, 0);
        do_ea(ACC_STACK, 0, `SEG_CODE, 64'h44, 64'h44, 0);
        do_ea(ACC_CODE, 0, `SEG_CODE, 64'h0001_0000_0000_0000, 0, 1);
        do_ea(ACC_CODE, 0, `SEG_CODE, 64'h80, 64'h80, 0);
        do_load(`SEG_STACK, 16'h0000, 1'b0);
        @(posedge clk);
        mode64 <= 1'b0;
        do_ea(ACC_DATA, 1, `SEG_XFIRST, 64'h10, 64'hFFFF_F010, 0);
        do_load(`SEG_STACK, 16'h0000, 1'b1);
        do_load(`SEG_CODE, 16'h0000, 1'b1);
        do_load(`SEG_XSECOND, 16'h0000, 1'b0);
        do_ea(ACC_DATA, 1, `SEG_XSECOND, 64'h10, 64'h0, 1);
        entry = mk(32'h0, 20'hFFFFF, 2'h3, 1'b1, 1'b1);
        do_load(`SEG_CODE, 16'h001B, 1'b0);
        chk(cur_priv, 2'h3, "priv");
        chk({cs_long, cs_dsize}, 2'b10, "code attrs");
        do_mrd(`MR_XFIRST_ADDR, 64'h0);
        chk(fault, 1'b1, "user mreg read fault");
        @(posedge clk);
        mode64 <= 1'b1;
        do_load(`SEG_STACK, 16'h0000, 1'b1);
        rd_sel(`SEG_CODE, 16'h001B);
        entry = mk(32'h00001000, 20'hFFFFF, 2'h3, 1'b1, 1'b0);
        do_load(`SEG_XSECOND, 16'h001B, 1'b0);
        do_ea(ACC_DATA, 1, `SEG_XSECOND, 64'h10, 64'h1010, 0);
        do_mwr(`MR_XSECOND_ADDR, 64'h0, 1);
        do_ea(ACC_DATA, 1, `SEG_XSECOND, 64'h20, 64'h1020, 0);
        do_ea(ACC_DATA, 1, `SEG_LTAB, 64'h10, 64'h0, 1);
        do_load(seg_idx_type'(3'h7), 16'h0010, 1'b1);
        report_and_stop();
    end
endmodule // segment_selector_register_unit_tb
